// *** verilog/ivc_pkg.sv ***
// Constants and types for the indicated value conditioner.
// Assumes a 200 MHz system clock and an APB register bus.
// Notes on behaviour
// - Zero beyond limit raises zero-limit error
// - Over-limit zero subtracts only the limit
// - Zero from key command or shorted pin
// - Zero leaves value at minus display offset
// - Zero reset discards the zero correction
// - Zero correction cleared at power-up
// - Moving average off or 2 to 999
// - Stable when 50 ms change stays small
// - Stable time 0.0-9.9 s, count 0-99
// - Zero time and count disable stability
// - Tracking zeroes after band dwell time
// - Tracking delay 0.0-9.9 s, band 0-99
// - Zero delay and band disable tracking
// - Tracking zero obeys the zero limit
// - No tracking outside the tracking band
// - Backlight dims after timers, touch restores
// - Both timers zero keep full brightness
// - Stable print mode prints on stability
// - Hold until near zero, release 1.5 s
// - No stable printing when stability disabled
// - Hold print: held gross, realtime net
// - Print off: realtime gross, hold net
// - Colour by comparison: green, yellow, red
// - Near zero when magnitude within setting
package ivc_pkg;

  typedef logic signed [19:0] ivc_val_t;

  typedef enum logic [1:0] {IVC_PM_OFF, IVC_PM_STABLE, IVC_PM_HOLD, IVC_PM_RSVD} ivc_pmode_t;
  typedef enum logic [1:0] {IVC_CM_YELLOW, IVC_CM_GREEN, IVC_CM_BLUE, IVC_CM_COMP} ivc_cmode_t;

  localparam logic [1:0] IVC_COL_YELLOW = 2'h0;
  localparam logic [1:0] IVC_COL_GREEN  = 2'h1;
  localparam logic [1:0] IVC_COL_BLUE   = 2'h2;
  localparam logic [1:0] IVC_COL_RED    = 2'h3;

  localparam logic [1:0] IVC_BL_OFF  = 2'h0;
  localparam logic [1:0] IVC_BL_DIM  = 2'h1;
  localparam logic [1:0] IVC_BL_FULL = 2'h2;

  localparam logic [7:0] IVC_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] IVC_ADDR_ZLIMIT = 8'h04;
  localparam logic [7:0] IVC_ADDR_DOFF   = 8'h08;
  localparam logic [7:0] IVC_ADDR_FILT   = 8'h0C;
  localparam logic [7:0] IVC_ADDR_STAB   = 8'h10;
  localparam logic [7:0] IVC_ADDR_TRACK  = 8'h14;
  localparam logic [7:0] IVC_ADDR_BLIGHT = 8'h18;
  localparam logic [7:0] IVC_ADDR_NZERO  = 8'h1C;
  localparam logic [7:0] IVC_ADDR_STATUS = 8'h20;
  localparam logic [7:0] IVC_ADDR_VALUE  = 8'h24;
  localparam logic [7:0] IVC_ADDR_ZCORR  = 8'h28;

  localparam int IVC_CTRL_ZERO   = 0;
  localparam int IVC_CTRL_ZRST   = 1;
  localparam int IVC_CTRL_PRINT  = 2;
  localparam int IVC_CTRL_ERRCLR = 3;
  localparam int IVC_CTRL_PMODE  = 4;
  localparam int IVC_CTRL_CMODE  = 6;
  localparam int IVC_CNT_LSB     = 0;
  localparam int IVC_TIME_LSB    = 8;

  localparam logic [3:0]  IVC_CTRL_RST   = 4'h0;
  localparam logic [16:0] IVC_ZLIMIT_RST = 17'h1869F;
  localparam logic [9:0]  IVC_FILT_MAX   = 10'h3E7;
  localparam logic [9:0]  IVC_FILT_MIN   = 10'h002;
  localparam logic [6:0]  IVC_SETTING_MAX = 7'h63;

  localparam int IVC_CLK_KHZ     = 200000;
  localparam int IVC_TICK_MS     = 50;
  localparam int IVC_TICK_CYC    = IVC_CLK_KHZ * IVC_TICK_MS;
  localparam int IVC_TENTH_MS    = 100;
  localparam int IVC_TENTH_TICKS = IVC_TENTH_MS / IVC_TICK_MS;
  localparam int IVC_REL_MS      = 1500;
  localparam logic [4:0] IVC_REL_TICKS = 5'(IVC_REL_MS / IVC_TICK_MS);
  localparam int IVC_MIN_MS      = 60000;
  localparam logic [10:0] IVC_MIN_TICKS = 11'(IVC_MIN_MS / IVC_TICK_MS);

  function automatic logic [19:0] ivc_abs(input ivc_val_t v);
    ivc_abs = v[19] ? 20'(-v) : 20'(v);
  endfunction

endpackage

// *** verilog/ivc_conditioner.sv ***
// Indicated value conditioner: filter, zero, stability, tracking,
// backlight, print trigger and colour, with an APB register file.
// Samples, hold and comparison inputs are on mclk_i; pins are not.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module ivc_conditioner
  import ivc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = IVC_TICK_CYC
)(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [19:0] sample_i,
  input  wire logic        sample_valid_i,
  input  wire logic        ext_zero_n_i,
  input  wire logic        touch_i,
  input  wire logic        hold_active_i,
  input  wire logic [19:0] hold_value_i,
  input  wire logic        cmp_pass_i,
  input  wire logic        upper_result_i,
  input  wire logic        lower_result_i,
  input  wire logic        outer_upper_result_i,
  input  wire logic        outer_lower_result_i,
  output logic      [19:0] indicated_o,
  output logic             stable_o,
  output logic             near_zero_o,
  output logic             zero_err_o,
  output logic      [1:0]  backlight_o,
  output logic      [1:0]  color_o,
  output logic             print_req_o,
  output logic      [19:0] print_gross_o,
  output logic      [19:0] print_net_o
);

  typedef enum logic [1:0] {IVC_PH_IDLE, IVC_PH_WAIT_NZ, IVC_PH_RELEASE} ivc_ph_t;

  logic              pready_reg;
  logic [31:0]       prdata_reg;
  logic              pslverr_reg;
  logic [3:0]        ctrl_reg;
  logic [16:0]       zlimit_reg;
  ivc_val_t          doff_reg;
  logic [9:0]        filt_len_reg;
  logic [6:0]        stab_cnt_set_reg;
  logic [6:0]        stab_time_reg;
  logic [6:0]        trk_band_reg;
  logic [6:0]        trk_time_reg;
  logic [6:0]        bl_on_reg;
  logic [6:0]        bl_low_reg;
  logic [16:0]       nz_set_reg;
  ivc_val_t          fbuf [0:1023];
  logic [9:0]        wptr_reg;
  logic [9:0]        fill_reg;
  logic signed [31:0] sum_reg;
  ivc_val_t          filt_reg;
  ivc_val_t          zc_reg;
  logic              zero_err_reg;
  logic              ez_s1_reg, ez_s2_reg, ez_s3_reg;
  logic              tc_s1_reg, tc_s2_reg;
  logic [23:0]       tick_cnt_reg;
  ivc_val_t          snap_reg;
  logic [7:0]        stab_ticks_reg;
  logic              stable_reg;
  logic              stable_d_reg;
  logic [7:0]        trk_ticks_reg;
  logic              near_zero_reg;
  ivc_ph_t           ph_state_reg;
  logic [4:0]        rel_cnt_reg;
  ivc_val_t          held_reg;
  logic              hold_d_reg;
  ivc_val_t          ind_reg;
  logic [10:0]       min_tick_reg;
  logic [7:0]        minutes_reg;
  logic [1:0]        bl_reg;
  logic [1:0]        color_reg;
  logic              print_reg;
  ivc_val_t          gross_reg;
  ivc_val_t          net_reg;

  // Register bus decode; the answer comes in the second access cycle
  wire access   = psel_i & penable_i;
  wire wr_fire  = access & pwrite_i & pready_reg;
  wire a_ctrl   = (paddr_i == IVC_ADDR_CTRL);
  wire a_zlim   = (paddr_i == IVC_ADDR_ZLIMIT);
  wire a_doff   = (paddr_i == IVC_ADDR_DOFF);
  wire a_filt   = (paddr_i == IVC_ADDR_FILT);
  wire a_stab   = (paddr_i == IVC_ADDR_STAB);
  wire a_trk    = (paddr_i == IVC_ADDR_TRACK);
  wire a_bl     = (paddr_i == IVC_ADDR_BLIGHT);
  wire a_nz     = (paddr_i == IVC_ADDR_NZERO);
  wire a_stat   = (paddr_i == IVC_ADDR_STATUS);
  wire a_val    = (paddr_i == IVC_ADDR_VALUE);
  wire a_zc     = (paddr_i == IVC_ADDR_ZCORR);
  wire a_ro     = a_stat | a_val | a_zc;
  wire a_hit    = a_ctrl | a_zlim | a_doff | a_filt | a_stab | a_trk | a_bl | a_nz | a_ro;
  wire bad      = ~a_hit | (pwrite_i & a_ro);
  wire wr_ok    = wr_fire & ~bad;
  wire cmd_zero = wr_ok & a_ctrl & pwdata_i[IVC_CTRL_ZERO];
  wire cmd_zrst = wr_ok & a_ctrl & pwdata_i[IVC_CTRL_ZRST];
  wire cmd_prn  = wr_ok & a_ctrl & pwdata_i[IVC_CTRL_PRINT];
  wire cmd_eclr = wr_ok & a_ctrl & pwdata_i[IVC_CTRL_ERRCLR];
  wire [1:0] pmode = ctrl_reg[1:0];
  wire [1:0] cmode = ctrl_reg[3:2];

  wire [31:0] rdata =
      a_ctrl ? {24'h0, cmode, pmode, 4'h0} :
      a_zlim ? {15'h0, zlimit_reg} :
      a_doff ? {{12{doff_reg[19]}}, doff_reg} :
      a_filt ? {22'h0, filt_len_reg} :
      a_stab ? {17'h0, stab_time_reg, 1'h0, stab_cnt_set_reg} :
      a_trk  ? {17'h0, trk_time_reg, 1'h0, trk_band_reg} :
      a_bl   ? {17'h0, bl_low_reg, 1'h0, bl_on_reg} :
      a_nz   ? {15'h0, nz_set_reg} :
      a_stat ? {24'h0, color_reg, bl_reg, (ph_state_reg != IVC_PH_IDLE),
                zero_err_reg, near_zero_reg, stable_reg} :
      a_val  ? {{12{ind_reg[19]}}, ind_reg} :
      a_zc   ? {{12{zc_reg[19]}}, zc_reg} : 32'h0;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= access & ~pready_reg;
      prdata_reg  <= (access & ~pready_reg & ~pwrite_i & ~bad) ? rdata : 32'h0;
      pslverr_reg <= access & ~pready_reg & bad;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg         <= IVC_CTRL_RST;
      zlimit_reg       <= IVC_ZLIMIT_RST;
      doff_reg         <= 20'h0;
      filt_len_reg     <= 10'h0;
      stab_cnt_set_reg <= 7'h0;
      stab_time_reg    <= 7'h0;
      trk_band_reg     <= 7'h0;
      trk_time_reg     <= 7'h0;
      bl_on_reg        <= 7'h0;
      bl_low_reg       <= 7'h0;
      nz_set_reg       <= 17'h0;
    end
    else if (wr_ok)
    begin
      if (a_ctrl) ctrl_reg <= pwdata_i[IVC_CTRL_CMODE+1:IVC_CTRL_PMODE];
      if (a_zlim) zlimit_reg <= pwdata_i[16:0];
      if (a_doff) doff_reg <= pwdata_i[19:0];
      if (a_filt) filt_len_reg <= pwdata_i[9:0];
      if (a_stab) stab_cnt_set_reg <= clamp99(pwdata_i[IVC_CNT_LSB+:7]);
      if (a_stab) stab_time_reg <= clamp99(pwdata_i[IVC_TIME_LSB+:7]);
      if (a_trk) trk_band_reg <= clamp99(pwdata_i[IVC_CNT_LSB+:7]);
      if (a_trk) trk_time_reg <= clamp99(pwdata_i[IVC_TIME_LSB+:7]);
      if (a_bl) bl_on_reg <= clamp99(pwdata_i[IVC_CNT_LSB+:7]);
      if (a_bl) bl_low_reg <= clamp99(pwdata_i[IVC_TIME_LSB+:7]);
      if (a_nz) nz_set_reg <= pwdata_i[16:0];
    end
  end

  function automatic logic [6:0] clamp99(input logic [6:0] v);
    clamp99 = (v > IVC_SETTING_MAX) ? IVC_SETTING_MAX : v;
  endfunction

  // Pin synchronisers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ez_s1_reg <= 1'b1;
      ez_s2_reg <= 1'b1;
      ez_s3_reg <= 1'b1;
      tc_s1_reg <= 1'b0;
      tc_s2_reg <= 1'b0;
    end
    else
    begin
      ez_s1_reg <= ext_zero_n_i;
      ez_s2_reg <= ez_s1_reg;
      ez_s3_reg <= ez_s2_reg;
      tc_s1_reg <= touch_i;
      tc_s2_reg <= tc_s1_reg;
    end
  end

  // Moving average over the last filt_len samples
  wire [9:0]  flen     = (filt_len_reg > IVC_FILT_MAX) ? IVC_FILT_MAX : filt_len_reg;
  wire        filt_on  = (flen >= IVC_FILT_MIN);
  wire        full     = (fill_reg == flen);
  wire [9:0]  old_idx  = wptr_reg - flen;
  wire signed [31:0] samp_x = {{12{sample_i[19]}}, sample_i};
  wire signed [31:0] old_x  = full ? {{12{fbuf[old_idx][19]}}, fbuf[old_idx]} : 32'sh0;
  wire signed [31:0] sum_next  = sum_reg + samp_x - old_x;
  wire [9:0]  fill_next = full ? fill_reg : fill_reg + 10'h1;
  wire signed [31:0] avg = sum_next / $signed({22'h0, fill_next});
  wire        flen_wr  = wr_ok & a_filt;

  always_ff @(posedge mclk_i)
  begin
    if (sample_valid_i & filt_on)
      fbuf[wptr_reg] <= sample_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i | flen_wr)
    begin
      wptr_reg <= 10'h0;
      fill_reg <= 10'h0;
      sum_reg  <= 32'sh0;
    end
    else if (sample_valid_i & filt_on)
    begin
      wptr_reg <= wptr_reg + 10'h1;
      fill_reg <= fill_next;
      sum_reg  <= sum_next;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      filt_reg <= 20'h0;
    else if (sample_valid_i)
      filt_reg <= filt_on ? avg[19:0] : sample_i;
  end

  // Zeroing: key command, pin shorted low, or tracking
  wire        tick     = (tick_cnt_reg == 24'(TICK_CYCLES - 1));
  wire        ext_zero = ez_s3_reg & ~ez_s2_reg;
  ivc_val_t   live;
  assign live = filt_reg - zc_reg - doff_reg;
  wire [19:0] disp_abs = ivc_abs(filt_reg - zc_reg);
  wire        trk_en   = (trk_time_reg != 7'h0) | (trk_band_reg != 7'h0);
  wire        in_band  = (disp_abs <= {13'h0, trk_band_reg});
  wire [7:0]  trk_need = 8'(trk_time_reg * IVC_TENTH_TICKS);
  wire        trk_fire = tick & trk_en & in_band & (trk_ticks_reg >= trk_need);
  wire        zero_req = cmd_zero | ext_zero | trk_fire;
  wire [19:0] z_abs    = ivc_abs(filt_reg);
  wire        z_over   = (z_abs > {3'h0, zlimit_reg});
  ivc_val_t   zlim_s;
  assign zlim_s = filt_reg[19] ? 20'(-$signed({3'h0, zlimit_reg})) : {3'h0, zlimit_reg};

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      zc_reg <= 20'h0;
    else if (cmd_zrst)
      zc_reg <= 20'h0;
    else if (zero_req)
      zc_reg <= z_over ? zlim_s : filt_reg;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      zero_err_reg <= 1'b0;
    else if (zero_req & ~cmd_zrst & z_over)
      zero_err_reg <= 1'b1;
    else if (cmd_eclr)
      zero_err_reg <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i | ~trk_en | ~in_band | zero_req | cmd_zrst)
      trk_ticks_reg <= 8'h0;
    else if (tick & (trk_ticks_reg != 8'hFF))
      trk_ticks_reg <= trk_ticks_reg + 8'h1;
  end

  // Stability detection on the 50 ms tick
  wire        stab_en   = (stab_time_reg != 7'h0) | (stab_cnt_set_reg != 7'h0);
  wire        quiet     = (ivc_abs(live - snap_reg) < {13'h0, stab_cnt_set_reg});
  wire [7:0]  stab_need = 8'(stab_time_reg * IVC_TENTH_TICKS);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      tick_cnt_reg <= 24'h0;
    else
      tick_cnt_reg <= tick ? 24'h0 : tick_cnt_reg + 24'h1;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      snap_reg       <= 20'h0;
      stab_ticks_reg <= 8'h0;
      stable_reg     <= 1'b0;
    end
    else if (tick)
    begin
      snap_reg <= live;
      if (~stab_en | ~quiet)
      begin
        stab_ticks_reg <= 8'h0;
        stable_reg     <= 1'b0;
      end
      else
      begin
        if (stab_ticks_reg != 8'hFF)
          stab_ticks_reg <= stab_ticks_reg + 8'h1;
        stable_reg <= (stab_ticks_reg >= stab_need);
      end
    end
  end

  // Near zero, stable print hold and print records
  wire        nz_now    = (ivc_abs(live) <= {3'h0, nz_set_reg});
  wire        stab_rise = stable_reg & ~stable_d_reg;
  wire        st_print  = (pmode == IVC_PM_STABLE) & stab_en & stab_rise;
  wire        hold_fall = hold_d_reg & ~hold_active_i;
  wire        hd_print  = (pmode == IVC_PM_HOLD) & hold_fall;
  wire        holding   = (ph_state_reg != IVC_PH_IDLE);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      ph_state_reg <= IVC_PH_IDLE;
      rel_cnt_reg  <= 5'h0;
      held_reg     <= 20'h0;
    end
    else
    begin
      case (ph_state_reg)
        IVC_PH_IDLE:
          if (st_print & ~near_zero_reg)
          begin
            held_reg     <= live;
            ph_state_reg <= IVC_PH_WAIT_NZ;
          end
        IVC_PH_WAIT_NZ:
          if (near_zero_reg)
          begin
            rel_cnt_reg  <= 5'h0;
            ph_state_reg <= IVC_PH_RELEASE;
          end
        IVC_PH_RELEASE:
          if (tick)
          begin
            rel_cnt_reg <= rel_cnt_reg + 5'h1;
            if (rel_cnt_reg == IVC_REL_TICKS - 5'h1)
              ph_state_reg <= IVC_PH_IDLE;
          end
        default:
          ph_state_reg <= IVC_PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      near_zero_reg <= 1'b0;
      stable_d_reg  <= 1'b0;
      hold_d_reg    <= 1'b0;
      ind_reg       <= 20'h0;
      print_reg     <= 1'b0;
      gross_reg     <= 20'h0;
      net_reg       <= 20'h0;
    end
    else
    begin
      near_zero_reg <= nz_now;
      stable_d_reg  <= stable_reg;
      hold_d_reg    <= hold_active_i;
      ind_reg       <= holding ? held_reg : live;
      print_reg     <= st_print | hd_print | cmd_prn;
      if (hd_print)
      begin
        gross_reg <= hold_value_i;
        net_reg   <= live;
      end
      else if (st_print | cmd_prn)
      begin
        gross_reg <= live;
        net_reg   <= hold_value_i;
      end
    end
  end

  // Backlight inactivity timers in minutes
  wire [7:0] on_min  = {1'b0, bl_on_reg};
  wire [7:0] dim_end = on_min + {1'b0, bl_low_reg};
  wire [1:0] bl_next =
      ((bl_on_reg == 7'h0) & (bl_low_reg == 7'h0)) ? IVC_BL_FULL :
      (minutes_reg < on_min)  ? IVC_BL_FULL :
      (minutes_reg < dim_end) ? IVC_BL_DIM : IVC_BL_OFF;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i | tc_s2_reg)
    begin
      min_tick_reg <= 11'h0;
      minutes_reg  <= 8'h0;
    end
    else if (tick)
    begin
      min_tick_reg <= (min_tick_reg == IVC_MIN_TICKS - 11'h1) ? 11'h0 : min_tick_reg + 11'h1;
      if ((min_tick_reg == IVC_MIN_TICKS - 11'h1) & (minutes_reg != 8'hFF))
        minutes_reg <= minutes_reg + 8'h1;
    end
  end

  // Display colour
  wire [1:0] cmp_col =
      (outer_upper_result_i | outer_lower_result_i) ? IVC_COL_RED :
      (upper_result_i | lower_result_i) ? IVC_COL_YELLOW :
      cmp_pass_i ? IVC_COL_GREEN : IVC_COL_YELLOW;
  wire [1:0] col_next =
      (cmode == IVC_CM_COMP)  ? cmp_col :
      (cmode == IVC_CM_GREEN) ? IVC_COL_GREEN :
      (cmode == IVC_CM_BLUE)  ? IVC_COL_BLUE : IVC_COL_YELLOW;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      bl_reg    <= IVC_BL_FULL;
      color_reg <= IVC_COL_YELLOW;
    end
    else
    begin
      bl_reg    <= bl_next;
      color_reg <= col_next;
    end
  end

  assign prdata_o      = prdata_reg;
  assign pready_o      = pready_reg;
  assign pslverr_o     = pslverr_reg;
  assign indicated_o   = ind_reg;
  assign stable_o      = stable_reg;
  assign near_zero_o   = near_zero_reg;
  assign zero_err_o    = zero_err_reg;
  assign backlight_o   = bl_reg;
  assign color_o       = color_reg;
  assign print_req_o   = print_reg;
  assign print_gross_o = gross_reg;
  assign print_net_o   = net_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  a_zero_limit_err: assert property (zero_req && !cmd_zrst && z_over |=> zero_err_reg)
    else $error("zero over limit did not raise error");
  a_zero_limit_sub: assert property (zero_req && !cmd_zrst && z_over
      |=> ivc_abs(zc_reg) == {3'h0, $past(zlimit_reg)})
    else $error("over-limit zero did not subtract the limit");
  a_zero_offset: assert property (zero_req && !cmd_zrst && !z_over
      |=> live == ivc_val_t'(filt_reg - $past(filt_reg) - doff_reg))
    else $error("zero did not leave minus offset");
  a_zero_reset: assert property (cmd_zrst |=> zc_reg == 20'h0)
    else $error("zero reset kept the correction");
  a_stab_disabled: assert property (tick && !stab_en |=> !stable_reg)
    else $error("stable shown while detector disabled");
  a_stab_break: assert property (tick && stab_en && !quiet
      |=> !stable_reg && stab_ticks_reg == 8'h0)
    else $error("large change did not clear stable");
  a_near_zero: assert property (nz_now |=> near_zero_o)
    else $error("near zero flag missing");
  a_bl_always: assert property (bl_on_reg == 7'h0 && bl_low_reg == 7'h0
      |=> bl_reg == IVC_BL_FULL)
    else $error("backlight not full with zero timers");
  a_bl_touch: assert property (tc_s2_reg && bl_on_reg != 7'h0 |=> ##1 bl_reg == IVC_BL_FULL)
    else $error("touch did not restore backlight");
  a_color_red: assert property (cmode == IVC_CM_COMP && outer_upper_result_i
      |=> color_o == IVC_COL_RED)
    else $error("outer result not shown red");
  a_hold_print: assert property (hd_print |=> print_req_o && print_gross_o == $past(hold_value_i))
    else $error("hold end print record wrong");
  a_print_gate: assert property (stab_rise && !stab_en |=> !print_req_o || $past(cmd_prn | hd_print))
    else $error("stable print while detector disabled");

endmodule

// *** sim/ivc_partner.sv ***
// Printer on the print port and the external zero contact.
// Assumes records come as a one-cycle request on mclk_i.
`timescale 1ns/100ps
module ivc_partner
(
  input  wire logic        mclk_i,
  input  wire logic        print_req_i,
  input  wire logic [19:0] gross_i,
  input  wire logic [19:0] net_i,
  output logic             ext_zero_n_o,
  output logic             got_o,
  output logic      [39:0] rec_o
);
  initial
  begin
    ext_zero_n_o = 1'b1;
    got_o = 1'b0;
  end
  // Printer takes the record with the request
  always @(posedge mclk_i)
  begin
    got_o <= print_req_i;
    if (print_req_i)
      rec_o <= {gross_i, net_i};
  end
  // Short the contact to the common return, then open it
  task automatic tap();
    @(posedge mclk_i) ext_zero_n_o <= 1'b0;
    repeat (6) @(posedge mclk_i);
    ext_zero_n_o <= 1'b1;
  endtask
endmodule

// *** sim/test_indicated_value_conditioner.sv ***
// Self-checking bench for the indicated value conditioner.
// Assumes ivc_pkg, ivc_conditioner and ivc_partner compiled first.
`timescale 1ns/100ps
module test_indicated_value_conditioner;
  import ivc_pkg::*;
  logic        mclk_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [19:0] sample_i, hold_value_i, indicated_o, print_gross_o, print_net_o;
  logic        sample_valid_i, ext_zero_n_i, touch_i, hold_active_i, cmp_pass_i;
  logic        upper_result_i, lower_result_i, outer_upper_result_i, outer_lower_result_i;
  logic        stable_o, near_zero_o, zero_err_o, print_req_o, got;
  logic [1:0]  backlight_o, color_o;
  logic [39:0] rec;
  logic [32:0] rq[$], mq[$];
  logic [39:0] pq[$];
  int          errors, num_checks;
  logic [15:0] rnd;
  ivc_val_t    s, d, l, hv;
  logic [1:0]  col[5] = '{IVC_COL_GREEN, IVC_COL_YELLOW, IVC_COL_YELLOW, IVC_COL_RED, IVC_COL_RED};

  ivc_conditioner #(.TICK_CYCLES(20)) i_ivc_conditioner (.mclk_i, .srst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .sample_i, .sample_valid_i, .ext_zero_n_i, .touch_i, .hold_active_i, .hold_value_i,
    .cmp_pass_i, .upper_result_i, .lower_result_i, .outer_upper_result_i,
    .outer_lower_result_i, .indicated_o, .stable_o, .near_zero_o, .zero_err_o,
    .backlight_o, .color_o, .print_req_o, .print_gross_o, .print_net_o);
  ivc_partner i_ivc_partner (.mclk_i, .print_req_i(print_req_o), .gross_i(print_gross_o),
    .net_i(print_net_o), .ext_zero_n_o(ext_zero_n_i), .got_o(got), .rec_o(rec));

  initial
  begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] v);
    num_checks++;
    if (v !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt,
                     input logic [32:0] e, input logic [32:0] m);
    repeat (3) @(posedge mclk_i);
    rq.push_back(e);
    mq.push_back(m);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= dt;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do
      @(posedge mclk_i);
    while (pready_o !== 1'b1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic err);
    apb(1'b1, a, dt, {err, 32'h0}, 33'h1_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, {1'b0, e}, {1'b1, m});
  endtask

  task automatic rv(input ivc_val_t x);
    rd(IVC_ADDR_VALUE, {12'h000, x}, 32'h000F_FFFF);
  endtask

  // One converter sample, then read back the indicated value
  task automatic feed(input ivc_val_t x, input ivc_val_t e);
    sample_i       <= x;
    sample_valid_i <= 1'b1;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    rv(e);
  endtask

  // Answers compared in order of request
  always @(posedge mclk_i)
  begin
    if (psel_i && penable_i && pready_o === 1'b1)
      chk("apb", 40'(rq.pop_front()), 40'({pslverr_o, prdata_o} & mq.pop_front()));
    if (got === 1'b1)
      chk("print", pq.pop_front(), rec);
  end

  initial
  begin
    repeat (40000) @(posedge mclk_i);
    errors++;
    wrap_up();
  end

  initial
  begin
    errors = 0;
    num_checks = 0;
    rnd = 16'h0045;
    srst_i = 1'b1;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {touch_i, hold_active_i, cmp_pass_i, upper_result_i, lower_result_i} = '0;
    {outer_upper_result_i, outer_lower_result_i} = '0;
    rnd = lfsr(rnd);
    s = 20'(rnd[13:0]) + 20'sh00010;
    rnd = lfsr(rnd);
    d = 20'(rnd[7:0]);
    rnd = lfsr(rnd);
    hv = 20'(rnd);
    l = s >>> 1;
    sample_i = s;
    hold_value_i = hv;
    sample_valid_i = 1'b1;
    repeat (20) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(IVC_ADDR_ZLIMIT, 32'(IVC_ZLIMIT_RST), 32'hFFFF_FFFF);
    apb(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0}, 33'h1_FFFF_FFFF);
    wr(IVC_ADDR_VALUE, 32'h1, 1'b1);
    wr(IVC_ADDR_FILT, 32'h0, 1'b0);
    wr(IVC_ADDR_STAB, 32'h0, 1'b0);
    wr(IVC_ADDR_TRACK, 32'h0, 1'b0);
    wr(IVC_ADDR_BLIGHT, 32'h0, 1'b0);
    wr(IVC_ADDR_DOFF, 32'(d), 1'b0);
    rv(s - d);
    $display("registers done");
    wr(IVC_ADDR_CTRL, 32'h1, 1'b0);
    rv(-d);
    wr(IVC_ADDR_CTRL, 32'h2, 1'b0);
    rv(s - d);
    wr(IVC_ADDR_ZLIMIT, 32'(l), 1'b0);
    wr(IVC_ADDR_CTRL, 32'h1, 1'b0);
    rv(s - l - d);
    rd(IVC_ADDR_STATUS, 32'h4, 32'h4);
    wr(IVC_ADDR_CTRL, 32'hA, 1'b0);
    wr(IVC_ADDR_ZLIMIT, 32'(IVC_ZLIMIT_RST), 1'b0);
    i_ivc_partner.tap();
    rv(-d);
    wr(IVC_ADDR_CTRL, 32'h2, 1'b0);
    $display("zero done");
    pq.push_back({s - d, hv});
    wr(IVC_ADDR_CTRL, 32'h4, 1'b0);
    wr(IVC_ADDR_CTRL, 32'h20, 1'b0);
    hold_active_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    pq.push_back({hv, s - d});
    hold_active_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    $display("print done");
    sample_valid_i <= 1'b0;
    wr(IVC_ADDR_FILT, 32'h2, 1'b0);
    feed(s, s - d);
    feed(s + d + d, s);
    feed(s + d + d, s + d);
    sample_i <= s;
    sample_valid_i <= 1'b1;
    wr(IVC_ADDR_FILT, 32'h0, 1'b0);
    $display("filter done");
    pq.push_back({s - d, hv});
    wr(IVC_ADDR_CTRL, 32'h10, 1'b0);
    wr(IVC_ADDR_STAB, 32'h105, 1'b0);
    repeat (100) @(posedge mclk_i);
    rd(IVC_ADDR_STATUS, 32'h9, 32'hF);
    sample_i <= s + 20'sh4;
    rv(s - d);
    wr(IVC_ADDR_NZERO, 32'h1FFFF, 1'b0);
    repeat (700) @(posedge mclk_i);
    rd(IVC_ADDR_STATUS, 32'h3, 32'hF);
    rv(s + 20'sh4 - d);
    $display("stable done");
    wr(IVC_ADDR_BLIGHT, 32'h1, 1'b0);
    wr(IVC_ADDR_CTRL, 32'hC0, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      {cmp_pass_i, upper_result_i, lower_result_i, outer_upper_result_i,
       outer_lower_result_i} <= 5'h10 >> k;
      touch_i <= rnd[k];
      rd(IVC_ADDR_STATUS, {24'h0, col[k], IVC_BL_FULL, 4'h0}, 32'hF0);
    end
    chk("color", 40'(IVC_COL_RED), 40'(color_o));
    chk("backlight", 40'(IVC_BL_FULL), 40'(backlight_o));
    chk("stable", 40'h1, 40'(stable_o));
    chk("near_zero", 40'h1, 40'(near_zero_o));
    chk("zero_err", 40'h0, 40'(zero_err_o));
    chk("indicated", 40'(s + 20'sh4 - d), 40'(indicated_o));
    $display("colour done");
    wrap_up();
  end
endmodule
